//--- verilog/bce_pkg.sv
// Package for the block copy engine: widths, field positions, codes and carrier types
package bce_pkg;
  localparam int WORD_W = 60;
  localparam int CNT_W = 18;
  localparam int BULK_AW = 30;
  localparam int MAIN_AW = 21;
  localparam logic [8:0] OP_BULK_TO_MAIN = 9'o011;
  localparam logic [8:0] OP_MAIN_TO_BULK = 9'o012;
  localparam int STD_OPND_HI = 22;
  localparam int STD_CHK_W = 24;
  localparam int EXP_OPND_HI = 28;
  localparam int EXP_CHK_W = 30;
  localparam int MAIN_FLD_LO = 30;
  localparam int MAIN_FLD_HI = 50;
  localparam int LIMIT_BIT_A = 21;
  localparam int LIMIT_BIT_B = 22;
  localparam logic [1:0] PARCEL_ZERO = 2'h0;
  localparam logic [1:0] PARCEL_TWO = 2'h2;
  localparam logic [CNT_W-1:0] CNT_RST = 18'h00000;

  // Exit codes reported at completion
  typedef enum logic [2:0] {
    BCE_EXIT_NEXT_WORD = 3'h0,
    BCE_EXIT_PARCEL2 = 3'h1,
    BCE_EXIT_ILLEGAL = 3'h2,
    BCE_EXIT_RANGE = 3'h3,
    BCE_EXIT_PASS = 3'h4
  } bce_exit_t;

  // Instruction issued to the engine
  typedef struct packed {
    logic [8:0] opcode;
    logic [1:0] parcel;
    logic [CNT_W-1:0] index_register_j;
    logic [CNT_W-1:0] count_imm;
    logic [WORD_W-1:0] extended_address_operand;
    logic [CNT_W-1:0] address_register_zero;
  } bce_cmd_t;

  // Exchange package flags and bases
  typedef struct packed {
    logic expanded_addr;
    logic block_copy;
    logic bulk_enable;
    logic [BULK_AW-1:0] extended_memory_base;
    logic [BULK_AW-1:0] extended_field_length;
    logic [MAIN_AW-1:0] main_memory_base;
  } bce_cfg_t;

  // Completion report
  typedef struct packed {
    bce_exit_t exit_code;
    logic [1:0] next_parcel;
    logic next_word;
  } bce_done_t;
endpackage

//--- verilog/bce_skid.sv
// Two-entry buffer in the copied word path
`timescale 1ns/100ps
module bce_skid (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [59:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [59:0] out_data_o
);
  logic [59:0] mem_reg [0:1];
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] cnt_reg;
  wire push = in_valid_i && (cnt_reg != 2'h2);
  wire pop = out_ready_i && (cnt_reg != 2'h0);

  assign in_ready_o = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o = mem_reg[rd_ptr_reg];

  // Storage write
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || flush_i) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- verilog/bce_engine.sv
// Block copy engine: moves counted runs of words between main and bulk memory
// Functional notes
// [R1] Opcode 011 copies j-plus-count words from bulk memory into main memory.
// [R2] Opcode 012 copies j-plus-count words from main memory into bulk memory.
// [R3] Standard mode: bulk address is operand bits 0..22 plus extended base.
// [R4] Expanded mode: bulk address is operand bits 0..28 plus extended base.
// [R5] Block copy flag clear: main address is address register zero plus base.
// [R6] Block copy flag set: main address is operand bits 30..50 plus base.
// [R7] Software keeps operand bits 51..59 zero when block copy flag set.
// [R8] Index j, operand and address register zero are left unchanged.
// [R9] Index j and count are 18-bit ones-complement; at most 131,071 words.
// [R10] A zero word count transfers nothing; acts as a full-word pass.
// [R11] Bulk address bit 21 or 22 set: no words, resume at parcel 2.
// [R12] Otherwise resume at parcel 0 of the next word after the copy.
// [R13] An interrupted copy is restarted from its first word.
// [R14] Illegal unless starting in parcel 0 with bulk memory enabled.
// [R15] Standard mode checks 24 operand bits against field length, bit 23 zero.
// [R16] Expanded mode checks 30 operand bits against field length, bit 29 zero.
// [R17] Checked operand bits at or above field length flag out of range.
// [R18] Negative word count takes an address range error exit.
// [R19] Software avoids overlapping source and destination fields.
// [R20] Words move one at a time, addresses stepping up by one.
`timescale 1ns/100ps
module bce_engine (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Instruction issue
  input wire logic cmd_valid_i,
  input wire bce_pkg::bce_cmd_t cmd_i,
  input wire bce_pkg::bce_cfg_t cfg_i,
  input wire logic interrupt_i,
  output logic cmd_ready_o,
  output logic busy_o,
  output logic done_o,
  output bce_pkg::bce_done_t done_info_o,
  output logic range_fault_o,
  // Main memory port
  output logic main_rd_o,
  output logic main_wr_o,
  output logic [20:0] main_addr_o,
  output logic [59:0] main_wdata_o,
  input wire logic main_ack_i,
  input wire logic [59:0] main_rdata_i,
  // Bulk memory port
  output logic bulk_rd_o,
  output logic bulk_wr_o,
  output logic [29:0] bulk_addr_o,
  output logic [59:0] bulk_wdata_o,
  input wire logic bulk_ack_i,
  input wire logic [59:0] bulk_rdata_i
);
  import bce_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Ones-complement 18-bit add with end-around carry
  function automatic logic [CNT_W-1:0] oc_add(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    logic [CNT_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    oc_add = s[CNT_W-1:0] + {{(CNT_W-1){1'b0}}, s[CNT_W]};
  endfunction

  // Ones-complement value is zero when all bits match
  function automatic logic oc_is_zero(input logic [CNT_W-1:0] v);
    oc_is_zero = (v == {CNT_W{1'b0}}) || (v == {CNT_W{1'b1}});
  endfunction

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_WAITR = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_FINISH = 5'b10000
  } bce_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Launch decode

  wire is_load = (cmd_i.opcode == OP_BULK_TO_MAIN); // R1
  wire is_store = (cmd_i.opcode == OP_MAIN_TO_BULK); // R2
  wire is_copy = is_load || is_store;
  wire [CNT_W-1:0] count_sum = oc_add(cmd_i.index_register_j, cmd_i.count_imm); // R9
  wire count_zero = oc_is_zero(count_sum); // R10
  wire count_neg = count_sum[CNT_W-1] && !count_zero; // R18
  wire [WORD_W-1:0] xo = cmd_i.extended_address_operand;
  // Operand field selected by addressing mode
  wire [BULK_AW-1:0] opnd_std = {{(BULK_AW-STD_OPND_HI-1){1'b0}}, xo[STD_OPND_HI:0]}; // R3
  wire [BULK_AW-1:0] opnd_exp = {{(BULK_AW-EXP_OPND_HI-1){1'b0}}, xo[EXP_OPND_HI:0]}; // R4
  wire [BULK_AW-1:0] bulk_opnd = cfg_i.expanded_addr ? opnd_exp : opnd_std;
  wire [BULK_AW-1:0] bulk_start = bulk_opnd + cfg_i.extended_memory_base;
  // Field length comparison with top bit forced low
  wire [STD_CHK_W-1:0] chk_std_op = xo[STD_CHK_W-1:0];
  wire [STD_CHK_W-1:0] chk_std_fl = {1'b0, cfg_i.extended_field_length[STD_CHK_W-2:0]}; // R15
  wire [EXP_CHK_W-1:0] chk_exp_op = xo[EXP_CHK_W-1:0];
  wire [EXP_CHK_W-1:0] chk_exp_fl = {1'b0, cfg_i.extended_field_length[EXP_CHK_W-2:0]}; // R16
  wire out_of_range = cfg_i.expanded_addr ? (chk_exp_op >= chk_exp_fl)
                                          : (chk_std_op >= chk_std_fl); // R17
  wire limit_hit = bulk_start[LIMIT_BIT_A] || bulk_start[LIMIT_BIT_B]; // R11
  // Main memory start address
  wire [MAIN_AW-1:0] main_src = cfg_i.block_copy ? xo[MAIN_FLD_HI:MAIN_FLD_LO]
                                                 : cmd_i.address_register_zero[MAIN_AW-1:0]; // R5 R6
  wire [MAIN_AW-1:0] main_start = main_src + cfg_i.main_memory_base;
  wire illegal = (cmd_i.parcel != PARCEL_ZERO) || !cfg_i.bulk_enable; // R14

  ////////////////////////////////////////////////////////////////////////////
  // State

  bce_state_t state_reg, state_next;
  logic dir_load_reg;
  logic [CNT_W-1:0] remain_reg;
  logic [BULK_AW-1:0] bulk_ptr_reg;
  logic [MAIN_AW-1:0] main_ptr_reg;
  logic [BULK_AW-1:0] bulk_start_reg;
  logic [MAIN_AW-1:0] main_start_reg;
  logic [CNT_W-1:0] count_reg;
  logic rd_pend_reg;
  logic wr_pend_reg;
  logic ready_reg;
  logic busy_reg;
  logic main_rd_reg;
  logic bulk_rd_reg;
  logic main_wr_reg;
  logic bulk_wr_reg;
  logic done_reg;
  bce_done_t done_info_reg;
  logic range_fault_reg;
  logic [BULK_AW-1:0] bulk_addr_reg;
  logic [MAIN_AW-1:0] main_addr_reg;
  logic [WORD_W-1:0] wdata_reg;

  // Buffer between source read data and destination write
  logic buf_in_ready;
  logic buf_out_valid;
  logic [WORD_W-1:0] buf_out_data;
  wire src_ack = dir_load_reg ? bulk_ack_i : main_ack_i;
  wire dst_ack = dir_load_reg ? main_ack_i : bulk_ack_i;
  wire [WORD_W-1:0] src_data = dir_load_reg ? bulk_rdata_i : main_rdata_i;
  wire rd_taken = rd_pend_reg && src_ack;
  wire wr_taken = wr_pend_reg && dst_ack;
  wire buf_pop = !wr_pend_reg && buf_out_valid && (state_reg != ST_IDLE);
  wire reads_left = (remain_reg != CNT_RST);
  wire can_read = reads_left && !rd_pend_reg && buf_in_ready && !interrupt_i;
  wire abort = interrupt_i && (state_reg != ST_IDLE); // R13
  wire launch = cmd_valid_i && (state_reg == ST_IDLE) && is_copy;
  wire all_written = !reads_left && !rd_pend_reg && !wr_pend_reg && !buf_out_valid;
  // Request strobes: raised on issue, dropped on ack, cleared on abort or idle
  wire strobe_clr = abort || (state_reg == ST_IDLE);
  wire rd_pend_next = !strobe_clr && (can_read || (rd_pend_reg && !rd_taken));
  wire wr_pend_next = !strobe_clr && (buf_pop || (wr_pend_reg && !wr_taken));

  bce_skid u_buf (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .flush_i(abort),
    .in_valid_i(rd_taken),
    .in_ready_o(buf_in_ready),
    .in_data_i(src_data),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (launch && !illegal && !count_neg && !out_of_range && !limit_hit && !count_zero) begin
          state_next = ST_READ;
        end
      end
      ST_READ, ST_WAITR, ST_WRITE: begin
        if (abort) begin
          state_next = ST_READ; // R13
        end else if (all_written) begin
          state_next = ST_FINISH;
        end else if (wr_pend_reg) begin
          state_next = ST_WRITE;
        end else if (rd_pend_reg) begin
          state_next = ST_WAITR;
        end else begin
          state_next = ST_READ;
        end
      end
      ST_FINISH: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ST_IDLE);
      busy_reg <= (state_next != ST_IDLE);
    end
  end

  // Launch captures copies; the caller's registers are never written back
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      dir_load_reg <= 1'b0;
      bulk_start_reg <= '0;
      main_start_reg <= '0;
      count_reg <= CNT_RST;
    end else if (launch) begin
      dir_load_reg <= is_load; // R8
      bulk_start_reg <= bulk_start;
      main_start_reg <= main_start;
      count_reg <= count_sum;
    end
  end

  // Word counter and address pointers
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      remain_reg <= CNT_RST;
      bulk_ptr_reg <= '0;
      main_ptr_reg <= '0;
    end else if (state_reg == ST_IDLE) begin
      remain_reg <= count_sum;
      bulk_ptr_reg <= bulk_start;
      main_ptr_reg <= main_start;
    end else if (abort) begin
      remain_reg <= count_reg; // R13
      bulk_ptr_reg <= bulk_start_reg;
      main_ptr_reg <= main_start_reg;
    end else begin
      if (can_read) begin
        remain_reg <= remain_reg - 18'h00001; // R20
      end
      if (can_read == dir_load_reg && can_read) begin
        bulk_ptr_reg <= bulk_ptr_reg + 30'h00000001; // R20
      end else if (buf_pop && !dir_load_reg) begin
        bulk_ptr_reg <= bulk_ptr_reg + 30'h00000001;
      end
      if (can_read && !dir_load_reg) begin
        main_ptr_reg <= main_ptr_reg + 21'h000001; // R20
      end else if (buf_pop && dir_load_reg) begin
        main_ptr_reg <= main_ptr_reg + 21'h000001;
      end
    end
  end

  // Memory request strobes, held until acknowledged
  // Direction only changes at launch, while all strobes are forced low
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rd_pend_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      main_rd_reg <= 1'b0;
      bulk_rd_reg <= 1'b0;
      main_wr_reg <= 1'b0;
      bulk_wr_reg <= 1'b0;
    end else begin
      rd_pend_reg <= rd_pend_next;
      wr_pend_reg <= wr_pend_next;
      main_rd_reg <= rd_pend_next && !dir_load_reg;
      bulk_rd_reg <= rd_pend_next && dir_load_reg;
      main_wr_reg <= wr_pend_next && dir_load_reg;
      bulk_wr_reg <= wr_pend_next && !dir_load_reg;
    end
  end

  // Address and data registers driving the memory ports
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      bulk_addr_reg <= '0;
      main_addr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      if (can_read && state_reg != ST_IDLE) begin
        if (dir_load_reg) begin
          bulk_addr_reg <= bulk_ptr_reg; // R1
        end else begin
          main_addr_reg <= main_ptr_reg; // R2
        end
      end
      if (buf_pop) begin
        wdata_reg <= buf_out_data;
        if (dir_load_reg) begin
          main_addr_reg <= main_ptr_reg;
        end else begin
          bulk_addr_reg <= bulk_ptr_reg;
        end
      end
    end
  end

  // Completion report and exit selection
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      done_reg <= 1'b0;
      done_info_reg <= '0;
      range_fault_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      range_fault_reg <= 1'b0;
      if (state_reg == ST_FINISH) begin
        done_reg <= 1'b1;
        done_info_reg <= '{BCE_EXIT_NEXT_WORD, PARCEL_ZERO, 1'b1}; // R12
      end else if (launch) begin
        if (illegal) begin
          done_reg <= 1'b1;
          done_info_reg <= '{BCE_EXIT_ILLEGAL, PARCEL_ZERO, 1'b0}; // R14
        end else if (count_neg || out_of_range) begin
          done_reg <= 1'b1;
          range_fault_reg <= 1'b1;
          done_info_reg <= '{BCE_EXIT_RANGE, PARCEL_ZERO, 1'b0}; // R17 R18
        end else if (limit_hit) begin
          done_reg <= 1'b1;
          done_info_reg <= '{BCE_EXIT_PARCEL2, PARCEL_TWO, 1'b0}; // R11
        end else if (count_zero) begin
          done_reg <= 1'b1;
          done_info_reg <= '{BCE_EXIT_PASS, PARCEL_ZERO, 1'b1}; // R10
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cmd_ready_o = ready_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign done_info_o = done_info_reg;
  assign range_fault_o = range_fault_reg;
  assign main_rd_o = main_rd_reg;
  assign bulk_rd_o = bulk_rd_reg;
  assign main_wr_o = main_wr_reg;
  assign bulk_wr_o = bulk_wr_reg;
  assign main_addr_o = main_addr_reg;
  assign bulk_addr_o = bulk_addr_reg;
  assign main_wdata_o = wdata_reg;
  assign bulk_wdata_o = wdata_reg;
endmodule

//--- bench/bce_mem.sv
// Behavioural memory port model: answers quickly and slowly in turn
`timescale 1ns/100ps
module bce_mem #(
  parameter logic [3:0] TAG = 4'h0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Request side
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [5:0] addr_i,
  input wire logic [59:0] wdata_i,
  // Answer side
  output logic ack_o,
  output logic [59:0] rdata_o
);
  logic [59:0] mem [64];
  logic [59:0] word_reg;
  logic [1:0] cnt_reg;
  logic slow_reg;
  // Fill with a tagged pattern
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {TAG, 56'(i)};
    end
  end
  // Read data is garbage outside the ack cycle
  assign rdata_o = ack_o ? word_reg : ~word_reg;
  // Ack after one or three cycles, alternating; plain always since the fill also writes mem
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      slow_reg <= 1'b0;
    end
    if (!nrst_i || !(rd_i || wr_i) || ack_o) begin
      cnt_reg <= 2'h0;
      ack_o <= 1'b0;
    end else if (cnt_reg == {slow_reg, 1'b0}) begin
      ack_o <= 1'b1;
      slow_reg <= ~slow_reg;
      word_reg <= mem[addr_i];
      if (wr_i) begin
        mem[addr_i] <= wdata_i;
      end
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
endmodule

//--- bench/bce_engine_checker.sv
// Port-level assertions for the block copy engine
`timescale 1ns/100ps
module bce_engine_checker (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Watched ports
  input wire logic cmd_valid_i,
  input wire bce_pkg::bce_cmd_t cmd_i,
  input wire bce_pkg::bce_cfg_t cfg_i,
  input wire logic interrupt_i,
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire bce_pkg::bce_done_t done_info_o,
  input wire logic range_fault_o,
  input wire logic main_rd_o,
  input wire logic main_wr_o,
  input wire logic [20:0] main_addr_o,
  input wire logic main_ack_i,
  input wire logic bulk_rd_o,
  input wire logic bulk_wr_o,
  input wire logic [59:0] bulk_wdata_o,
  input wire logic bulk_ack_i
);
  import bce_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic [8:0] op_reg;
  logic [18:0] sum_w;
  logic [17:0] oc_w;
  // Decode of an accepted, legal command
  wire take_w = cmd_valid_i && cmd_ready_o && (cmd_i.opcode == OP_BULK_TO_MAIN || cmd_i.opcode == OP_MAIN_TO_BULK);
  wire legal_w = take_w && cmd_i.parcel == PARCEL_ZERO && cfg_i.bulk_enable;
  assign sum_w = {1'b0, cmd_i.index_register_j} + {1'b0, cmd_i.count_imm};
  assign oc_w = sum_w[17:0] + {17'h0, sum_w[18]};
  wire zero_w = oc_w == 18'h0 || oc_w == 18'h3ffff;
  // Direction of the running command
  always_ff @(posedge mclk_i) begin
    if (take_w) begin
      op_reg <= cmd_i.opcode;
    end
  end
  AST_ILLEGAL: assert property (take_w && !legal_w
    |-> ##[1:2] done_o && done_info_o.exit_code == BCE_EXIT_ILLEGAL) else $error("illegal command not refused");
  AST_RANGE_STD: assert property (legal_w && !cfg_i.expanded_addr
    && cmd_i.extended_address_operand[23:0] >= {1'b0, cfg_i.extended_field_length[22:0]}
    |-> ##[1:2] done_o && range_fault_o) else $error("standard range check missed");
  AST_RANGE_EXP: assert property (legal_w && cfg_i.expanded_addr
    && cmd_i.extended_address_operand[29:0] >= {1'b0, cfg_i.extended_field_length[28:0]}
    |-> ##[1:2] done_o && range_fault_o) else $error("expanded range check missed");
  AST_NEG: assert property (legal_w && oc_w[17] && oc_w != 18'h3ffff |-> ##[1:2] done_o && range_fault_o)
    else $error("negative count not faulted");
  AST_ZERO: assert property (legal_w && zero_w |-> ##[1:2] done_o && done_info_o.exit_code != BCE_EXIT_NEXT_WORD)
    else $error("zero count copied");
  AST_FAULT: assert property (range_fault_o |-> done_o && done_info_o.exit_code == BCE_EXIT_RANGE)
    else $error("fault without range exit");
  AST_PARCEL2: assert property (done_o && done_info_o.exit_code == BCE_EXIT_PARCEL2
    |-> done_info_o.next_parcel == PARCEL_TWO) else $error("parcel two not reported");
  AST_NEXT: assert property (done_o && done_info_o.exit_code == BCE_EXIT_NEXT_WORD
    |-> done_info_o.next_parcel == PARCEL_ZERO && done_info_o.next_word) else $error("bad resume point");
  AST_DIR: assert property (!cmd_ready_o && op_reg == OP_BULK_TO_MAIN |-> !main_rd_o && !bulk_wr_o)
    else $error("wrong direction");
  AST_HOLD: assert property (main_rd_o && !main_ack_i && !interrupt_i |=> main_rd_o && $stable(main_addr_o))
    else $error("main request dropped early");
  AST_WHOLD: assert property (bulk_wr_o && !bulk_ack_i && !interrupt_i |=> bulk_wr_o && $stable(bulk_wdata_o))
    else $error("bulk write unstable");
endmodule
bind bce_engine bce_engine_checker i_bce_engine_checker (.mclk_i, .nrst_i, .cmd_valid_i, .cmd_i, .cfg_i, .interrupt_i,
  .cmd_ready_o, .done_o, .done_info_o, .range_fault_o, .main_rd_o, .main_wr_o, .main_addr_o, .main_ack_i,
  .bulk_rd_o, .bulk_wr_o, .bulk_wdata_o, .bulk_ack_i);

//--- bench/block_copy_engine_test.sv
// Directed testbench for the block copy engine
`timescale 1ns/100ps
module block_copy_engine_test;
  import bce_pkg::*;
  logic mclk_i, nrst_i, cmd_valid_i, interrupt_i, cmd_ready_o, busy_o, done_o, range_fault_o;
  bce_cmd_t cmd_i;
  bce_cfg_t cfg_i;
  bce_done_t done_info_o;
  logic main_rd_o, main_wr_o, main_ack_i, bulk_rd_o, bulk_wr_o, bulk_ack_i;
  logic [20:0] main_addr_o;
  logic [29:0] bulk_addr_o;
  logic [59:0] main_wdata_o, main_rdata_i, bulk_wdata_o, bulk_rdata_i;
  int n_mismatch = 0;
  int n_checks = 0;
  // Exchange settings: standard, expanded, disabled
  localparam bce_cfg_t STD = '{1'b0, 1'b0, 1'b1, 30'h10, 30'h100000, 21'h20};
  localparam bce_cfg_t EXP = '{1'b1, 1'b1, 1'b1, 30'h10, 30'h1000000, 21'h20};
  localparam bce_cfg_t OFF = '{1'b0, 1'b0, 1'b0, 30'h10, 30'h100000, 21'h20};
  ////////////////////////////////////////////////////////////////////////
  // Design and memories
  bce_engine i_bce_engine (.mclk_i(mclk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cfg_i(cfg_i), .interrupt_i(interrupt_i), .cmd_ready_o(cmd_ready_o), .busy_o(busy_o), .done_o(done_o),
    .done_info_o(done_info_o), .range_fault_o(range_fault_o), .main_rd_o(main_rd_o), .main_wr_o(main_wr_o),
    .main_addr_o(main_addr_o), .main_wdata_o(main_wdata_o), .main_ack_i(main_ack_i), .main_rdata_i(main_rdata_i),
    .bulk_rd_o(bulk_rd_o), .bulk_wr_o(bulk_wr_o), .bulk_addr_o(bulk_addr_o), .bulk_wdata_o(bulk_wdata_o),
    .bulk_ack_i(bulk_ack_i), .bulk_rdata_i(bulk_rdata_i));
  bce_mem #(.TAG(4'ha)) i_bce_mem_main (.mclk_i(mclk_i), .nrst_i(nrst_i), .rd_i(main_rd_o), .wr_i(main_wr_o),
    .addr_i(main_addr_o[5:0]), .wdata_i(main_wdata_o), .ack_o(main_ack_i), .rdata_o(main_rdata_i));
  bce_mem #(.TAG(4'hb)) i_bce_mem_bulk (.mclk_i(mclk_i), .nrst_i(nrst_i), .rd_i(bulk_rd_o), .wr_i(bulk_wr_o),
    .addr_i(bulk_addr_o[5:0]), .wdata_i(bulk_wdata_o), .ack_o(bulk_ack_i), .rdata_o(bulk_rdata_i));
  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // Compare and count
  task check(input logic [59:0] seen, input logic [59:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task give_verdict;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Issue one command, optionally interrupt it, wait for completion
  task run(input bce_cmd_t c, input bce_cfg_t f, input bce_exit_t e, input int irq_at);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1) @(negedge mclk_i);
    cmd_i = c;
    cfg_i = f;
    cmd_valid_i = 1'b1;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 3000) begin
      @(negedge mclk_i);
      n++;
      interrupt_i = irq_at != 0 && n >= irq_at && n < irq_at + 2;
    end
    interrupt_i = 1'b0;
    if (n >= 3000) n_mismatch++;
    check(done_info_o.exit_code, e);
    check(range_fault_o, e == BCE_EXIT_RANGE);
    check(busy_o, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence; operand bits 51..59 kept zero and fields never overlap
  initial begin
    nrst_i = 1'b0;
    cmd_valid_i = 1'b0;
    interrupt_i = 1'b0;
    cmd_i = '0;
    cfg_i = STD;
    repeat (4) @(negedge mclk_i);
    nrst_i = 1'b1;
    run('{OP_BULK_TO_MAIN, PARCEL_ZERO, 18'h1, 18'h2, 60'h1000002, 18'h3}, STD, BCE_EXIT_NEXT_WORD, 0);
    check(done_info_o.next_parcel, PARCEL_ZERO);
    check(done_info_o.next_word, 1'b1);
    for (int i = 0; i < 3; i++) check(i_bce_mem_main.mem[35 + i], {4'hb, 56'(18 + i)});
    check(i_bce_mem_main.mem[38], {4'ha, 56'h26});
    run('{OP_MAIN_TO_BULK, PARCEL_ZERO, 18'h2, 18'h0, 60'h200800005, 18'h3}, EXP, BCE_EXIT_NEXT_WORD, 6);
    for (int i = 0; i < 2; i++) check(i_bce_mem_bulk.mem[21 + i], {4'ha, 56'(40 + i)});
    check(i_bce_mem_bulk.mem[23], {4'hb, 56'h17});
    run('{OP_BULK_TO_MAIN, PARCEL_ZERO, 18'h5, 18'h3fffa, 60'h2, 18'h0}, STD, BCE_EXIT_PASS, 0);
    run('{OP_MAIN_TO_BULK, PARCEL_ZERO, 18'h0, 18'h0, 60'h2, 18'h0}, STD, BCE_EXIT_PASS, 0);
    run('{OP_BULK_TO_MAIN, PARCEL_ZERO, 18'h0, 18'h3fffe, 60'h2, 18'h0}, STD, BCE_EXIT_RANGE, 0);
    run('{OP_BULK_TO_MAIN, 2'h1, 18'h1, 18'h0, 60'h2, 18'h0}, STD, BCE_EXIT_ILLEGAL, 0);
    run('{OP_MAIN_TO_BULK, PARCEL_ZERO, 18'h1, 18'h0, 60'h2, 18'h0}, OFF, BCE_EXIT_ILLEGAL, 0);
    run('{OP_BULK_TO_MAIN, PARCEL_ZERO, 18'h1, 18'h0, 60'h100000, 18'h0}, STD, BCE_EXIT_RANGE, 0);
    run('{OP_BULK_TO_MAIN, PARCEL_ZERO, 18'h0, 18'h0, 60'h1000000, 18'h0}, STD, BCE_EXIT_PASS, 0);
    run('{OP_BULK_TO_MAIN, PARCEL_ZERO, 18'h0, 18'h0, 60'h1000000, 18'h0}, EXP, BCE_EXIT_RANGE, 0);
    run('{OP_BULK_TO_MAIN, PARCEL_ZERO, 18'h1, 18'h0, 60'h1ffff0, 18'h0}, EXP, BCE_EXIT_PARCEL2, 0);
    check(done_info_o.next_parcel, PARCEL_TWO);
    check(i_bce_mem_main.mem[32], {4'ha, 56'h20});
    give_verdict();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    give_verdict();
  end
endmodule
